/* File: logic/pgd_alu.sv */
// Rotate and logical function stage for one write byte against one latch.
`timescale 1ns/100ps
module pgd_alu (
   // Operands.
   input wire logic [7:0] data_in,
   input wire logic [7:0] latch_in,
   // Controls.
   input wire logic [2:0] rot_cnt,
   input wire pgd_pkg::pgd_fn_t fn,
   // Result.
   output logic [7:0] result
);
   logic [15:0] dbl;
   logic [7:0] rot;
   always_comb begin
      dbl = {data_in, data_in} >> rot_cnt;
      rot = dbl[7:0];
      case (fn)
         pgd_pkg::PGD_FN_AND: result = rot & latch_in;
         pgd_pkg::PGD_FN_OR: result = rot | latch_in;
         pgd_pkg::PGD_FN_XOR: result = rot ^ latch_in;
         default: result = rot;
      endcase
   end
endmodule

/* File: logic/pgd_cmp.sv */
// Colour compare of four plane bytes against a compare colour.
`timescale 1ns/100ps
module pgd_cmp (
   // Plane data.
   input wire logic [31:0] planes,
   // Compare settings.
   input wire logic [3:0] colour,
   input wire logic [3:0] care,
   // Result.
   output logic [7:0] match
);
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         logic [3:0] pix;
         assign pix = {planes[24+b], planes[16+b], planes[8+b], planes[b]};
         assign match[b] = ((pix ^ colour) & care) == 4'h0;
      end
   endgenerate
endmodule

/* File: logic/pgd_datapath.sv */
// Plane data path: indexed registers, plane writes and plane reads.
`timescale 1ns/100ps
`include "pgd_params.svh"
module pgd_datapath (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Host I/O port.
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // Host memory cycle.
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   // Sequencer state.
   input wire logic [7:0] sequencer_memory_mode,
   // Display memory planes.
   input wire logic [31:0] plane_rdata,
   output logic [31:0] plane_wdata,
   output logic plane_we
);
   logic [3:0] controller_index_pointer_q;
   logic [3:0] plane_set_reset_value_q;
   logic [3:0] plane_set_reset_enable_q;
   logic [3:0] compare_colour_q;
   logic [4:0] rotate_and_function_q;
   logic [1:0] read_plane_select_q;
   logic [3:0] controller_mode_register_q;
   logic [3:0] compare_dont_care_mask_q;
   logic [7:0] write_bit_mask_q;
   logic [31:0] latch_q;
   logic [7:0] io_rdata_d;
   logic [7:0] mem_rdata_d;
   logic [31:0] plane_wdata_d;
   logic [7:0] cmp_match;
   logic [1:0] wmode;
   logic rd_cmp;
   logic [1:0] rd_plane;
   logic data_wr;
   logic [2:0] rot_cnt;
   pgd_pkg::pgd_fn_t fn;
   pgd_pkg::pgd_state_t state_q;

   assign wmode = controller_mode_register_q[`PGD_MODE_WMODE_HI:`PGD_MODE_WMODE_LO];
   assign rd_cmp = controller_mode_register_q[`PGD_MODE_RDMODE];
   assign rd_plane = sequencer_memory_mode[`PGD_FOUR_PLANE_CHAINING_BIT] ? 2'h0 : read_plane_select_q;
   assign data_wr = io_wr && (io_addr == `PGD_PORT_DATA);
   assign rot_cnt = rotate_and_function_q[`PGD_ROT_CNT_HI:`PGD_ROT_CNT_LO];
   assign fn = pgd_pkg::pgd_fn_t'(rotate_and_function_q[`PGD_ROT_FN_HI:`PGD_ROT_FN_LO]);

   // Index register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         controller_index_pointer_q <= 4'h0;
      end else if (io_wr && io_addr == `PGD_PORT_INDEX) begin
         controller_index_pointer_q <= io_wdata[3:0];
      end
   end

   // Indexed registers, written through the data port.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         plane_set_reset_value_q <= 4'h0;
         plane_set_reset_enable_q <= 4'h0;
         compare_colour_q <= 4'h0;
         rotate_and_function_q <= 5'h00;
         read_plane_select_q <= 2'h0;
         controller_mode_register_q <= 4'h0;
         compare_dont_care_mask_q <= `PGD_RST_DC;
         write_bit_mask_q <= `PGD_RST_MASK;
      end else if (data_wr) begin
         if (controller_index_pointer_q == `PGD_IDX_SRV) begin
            plane_set_reset_value_q <= io_wdata[3:0];
         end else if (controller_index_pointer_q == `PGD_IDX_SRE) begin
            plane_set_reset_enable_q <= io_wdata[3:0];
         end else if (controller_index_pointer_q == `PGD_IDX_CMP) begin
            compare_colour_q <= io_wdata[3:0];
         end else if (controller_index_pointer_q == `PGD_IDX_ROT) begin
            rotate_and_function_q <= io_wdata[4:0];
         end else if (controller_index_pointer_q == `PGD_IDX_MAP) begin
            read_plane_select_q <= io_wdata[1:0];
         end else if (controller_index_pointer_q == `PGD_IDX_MODE) begin
            controller_mode_register_q <= 4'(io_wdata & `PGD_MODE_MASK);
         end else if (controller_index_pointer_q == `PGD_IDX_DC) begin
            compare_dont_care_mask_q <= io_wdata[3:0];
         end else if (controller_index_pointer_q == `PGD_IDX_MASK) begin
            write_bit_mask_q <= io_wdata;
         end
      end
   end

   // I/O read-back mux.
   always_comb begin
      io_rdata_d = `PGD_RST_BYTE;
      if (io_addr == `PGD_PORT_INDEX) begin
         io_rdata_d = {4'h0, controller_index_pointer_q};
      end else if (io_addr == `PGD_PORT_DATA) begin
         if (controller_index_pointer_q == `PGD_IDX_SRV) begin
            io_rdata_d = {4'h0, plane_set_reset_value_q};
         end else if (controller_index_pointer_q == `PGD_IDX_SRE) begin
            io_rdata_d = {4'h0, plane_set_reset_enable_q};
         end else if (controller_index_pointer_q == `PGD_IDX_CMP) begin
            io_rdata_d = {4'h0, compare_colour_q};
         end else if (controller_index_pointer_q == `PGD_IDX_ROT) begin
            io_rdata_d = {3'h0, rotate_and_function_q};
         end else if (controller_index_pointer_q == `PGD_IDX_MAP) begin
            io_rdata_d = {6'h00, read_plane_select_q};
         end else if (controller_index_pointer_q == `PGD_IDX_MODE) begin
            io_rdata_d = {4'h0, controller_mode_register_q};
         end else if (controller_index_pointer_q == `PGD_IDX_DC) begin
            io_rdata_d = {4'h0, compare_dont_care_mask_q};
         end else if (controller_index_pointer_q == `PGD_IDX_MASK) begin
            io_rdata_d = write_bit_mask_q;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         io_rdata <= `PGD_RST_BYTE;
      end else if (io_rd) begin
         io_rdata <= io_rdata_d;
      end
   end

   // Colour compare of the planes being read.
   pgd_cmp u_cmp (
      .planes(plane_rdata),
      .colour(compare_colour_q),
      .care(compare_dont_care_mask_q),
      .match(cmp_match)
   );

   // Memory read: latch all planes, return plane or compare result.
   always_comb begin
      if (rd_cmp) begin
         mem_rdata_d = cmp_match;
      end else begin
         mem_rdata_d = plane_rdata[rd_plane*8 +: 8];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         latch_q <= 32'h00000000;
         mem_rdata <= `PGD_RST_BYTE;
      end else if (mem_rd) begin
         latch_q <= plane_rdata;
         mem_rdata <= mem_rdata_d;
      end
   end

   // Per-plane write data.
   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_plane
         logic [7:0] alu_out;
         logic [7:0] srb;
         logic [7:0] src;
         logic [7:0] lat;
         assign lat = latch_q[p*8 +: 8];
         pgd_alu u_alu (
            .data_in(mem_wdata),
            .latch_in(lat),
            .rot_cnt(rot_cnt),
            .fn(fn),
            .result(alu_out)
         );
         assign srb = {8{plane_set_reset_value_q[p]}};
         always_comb begin
            if (wmode == 2'h1) begin
               src = lat;
            end else if (plane_set_reset_enable_q[p]) begin
               src = srb;
            end else begin
               src = alu_out;
            end
         end
         assign plane_wdata_d[p*8 +: 8] = (src & write_bit_mask_q)
            | (lat & ~write_bit_mask_q);
      end
   endgenerate

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         plane_wdata <= 32'h00000000;
         plane_we <= 1'b0;
      end else begin
         plane_we <= mem_wr;
         if (mem_wr) begin
            plane_wdata <= plane_wdata_d;
         end
      end
   end

   // Cycle tracker used by the checks.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= pgd_pkg::PGD_ST_IDLE;
      end else begin
         case (1'b1)
            mem_wr: state_q <= pgd_pkg::PGD_ST_WRITE;
            mem_rd: state_q <= pgd_pkg::PGD_ST_READ;
            default: state_q <= pgd_pkg::PGD_ST_IDLE;
         endcase
      end
   end

   property p_idx_low4;
      @(posedge clock) disable iff (rst)
      io_wr && io_addr == `PGD_PORT_INDEX |=> controller_index_pointer_q == $past(io_wdata[3:0]);
   endproperty
   a_idx_low4: assert property (p_idx_low4) else $error("index not taken");

   property p_sr_write;
      @(posedge clock) disable iff (rst)
      mem_wr && wmode == 2'h0 && plane_set_reset_enable_q[0] && write_bit_mask_q == 8'hFF
      |=> plane_wdata[7:0] == {8{$past(plane_set_reset_value_q[0])}};
   endproperty
   a_sr_write: assert property (p_sr_write) else $error("set/reset data wrong");

   property p_sre_isolated;
      @(posedge clock) disable iff (rst)
      mem_wr && wmode == 2'h0 && !plane_set_reset_enable_q[1] && plane_set_reset_enable_q[0]
      && write_bit_mask_q == 8'hFF && rot_cnt == 3'h0 && fn == pgd_pkg::PGD_FN_PASS
      |=> plane_wdata[15:8] == $past(mem_wdata);
   endproperty
   a_sre_isolated: assert property (p_sre_isolated) else $error("enable leaked");

   property p_cmp_read;
      @(posedge clock) disable iff (rst)
      mem_rd && rd_cmp |=> mem_rdata == $past(cmp_match);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare read wrong");

   property p_map_read;
      @(posedge clock) disable iff (rst)
      mem_rd && !rd_cmp && !sequencer_memory_mode[`PGD_FOUR_PLANE_CHAINING_BIT]
      |=> mem_rdata == $past(plane_rdata[read_plane_select_q*8 +: 8]);
   endproperty
   a_map_read: assert property (p_map_read) else $error("plane read wrong");

   property p_mask_keep;
      @(posedge clock) disable iff (rst)
      mem_wr |=> ((plane_wdata[7:0] ^ $past(latch_q[7:0])) & ~$past(write_bit_mask_q)) == 8'h00;
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("masked bit changed");

   property p_mode1;
      @(posedge clock) disable iff (rst)
      mem_wr && wmode == 2'h1 |=> plane_wdata == $past(latch_q);
   endproperty
   a_mode1: assert property (p_mode1) else $error("mode 1 write wrong");

   property p_upper_zero;
      @(posedge clock) disable iff (rst)
      io_rd && io_addr == `PGD_PORT_DATA && controller_index_pointer_q == `PGD_IDX_MAP
      |=> io_rdata[7:2] == 6'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

   property p_chain_read;
      @(posedge clock) disable iff (rst)
      mem_rd && !rd_cmp && sequencer_memory_mode[`PGD_FOUR_PLANE_CHAINING_BIT]
      |=> mem_rdata == $past(plane_rdata[7:0]);
   endproperty
   a_chain_read: assert property (p_chain_read) else $error("chained read wrong");

   property p_rot_pass;
      @(posedge clock) disable iff (rst)
      mem_wr && wmode != 2'h1 && !plane_set_reset_enable_q[0] && write_bit_mask_q == 8'hFF
      && fn == pgd_pkg::PGD_FN_PASS
      |=> plane_wdata[7:0] == $past(8'({mem_wdata, mem_wdata} >> rot_cnt));
   endproperty
   a_rot_pass: assert property (p_rot_pass) else $error("rotated data wrong");

   property p_dc_none;
      @(posedge clock) disable iff (rst)
      mem_rd && rd_cmp && compare_dont_care_mask_q == 4'h0 |=> mem_rdata == 8'hFF;
   endproperty
   a_dc_none: assert property (p_dc_none) else $error("excluded plane compared");

   property p_write_pulse;
      @(posedge clock) disable iff (rst)
      mem_wr |=> plane_we && state_q == pgd_pkg::PGD_ST_WRITE;
   endproperty
   a_write_pulse: assert property (p_write_pulse) else $error("plane write missing");

   property p_read_track;
      @(posedge clock) disable iff (rst)
      mem_rd && !mem_wr |=> state_q == pgd_pkg::PGD_ST_READ && !plane_we;
   endproperty
   a_read_track: assert property (p_read_track) else $error("read wrote planes");

   property p_idx_upper;
      @(posedge clock) disable iff (rst)
      io_rd && io_addr == `PGD_PORT_INDEX |=> io_rdata[7:4] == 4'h0;
   endproperty
   a_idx_upper: assert property (p_idx_upper) else $error("index upper bits set");

   c_cmp: cover property (@(posedge clock) disable iff (rst) mem_rd && rd_cmp);
   c_mode1: cover property (@(posedge clock) disable iff (rst) mem_wr && wmode == 2'h1);
   c_sr: cover property (@(posedge clock) disable iff (rst)
      mem_wr && plane_set_reset_enable_q != 4'h0);
   c_chain: cover property (@(posedge clock) disable iff (rst)
      mem_rd && sequencer_memory_mode[`PGD_FOUR_PLANE_CHAINING_BIT]);
endmodule

/* File: logic/pgd_params.svh */
// Register offsets, field positions and encodings of the plane data path.
`ifndef PGD_PARAMS_SVH
`define PGD_PARAMS_SVH
`define PGD_PORT_INDEX 16'h03CE
`define PGD_PORT_DATA 16'h03CF
`define PGD_IDX_SRV 4'h0
`define PGD_IDX_SRE 4'h1
`define PGD_IDX_CMP 4'h2
`define PGD_IDX_ROT 4'h3
`define PGD_IDX_MAP 4'h4
`define PGD_IDX_MODE 4'h5
`define PGD_IDX_DC 4'h7
`define PGD_IDX_MASK 4'h8
`define PGD_MODE_RDMODE 3
`define PGD_MODE_WMODE_HI 1
`define PGD_MODE_WMODE_LO 0
`define PGD_ROT_FN_HI 4
`define PGD_ROT_FN_LO 3
`define PGD_ROT_CNT_HI 2
`define PGD_ROT_CNT_LO 0
`define PGD_FOUR_PLANE_CHAINING_BIT 3
`define PGD_NIB_MASK 8'h0F
`define PGD_MAP_MASK 8'h03
`define PGD_ROT_MASK 8'h1F
`define PGD_MODE_MASK 8'h0B
`define PGD_RST_BYTE 8'h00
`define PGD_RST_MASK 8'hFF
`define PGD_RST_DC 4'hF
`endif

/* File: logic/pgd_pkg.sv */
// Types shared by the plane data path modules.
package pgd_pkg;
   typedef enum logic [1:0] {
      PGD_FN_PASS = 2'h0,
      PGD_FN_AND = 2'h1,
      PGD_FN_OR = 2'h2,
      PGD_FN_XOR = 2'h3
   } pgd_fn_t;
   typedef enum logic [2:0] {
      PGD_ST_IDLE = 3'h1,
      PGD_ST_READ = 3'h2,
      PGD_ST_WRITE = 3'h4
   } pgd_state_t;
endpackage

/* File: test/pgd_plane_mem.sv */
// Behavioural display memory holding one location of all four planes.
`timescale 1ns/100ps
module pgd_plane_mem (
   // Clock.
   input wire logic clock,
   // Plane port.
   input wire logic [31:0] plane_wdata,
   input wire logic plane_we,
   output logic [31:0] plane_rdata,
   // Preload from the bench.
   input wire logic load,
   input wire logic [31:0] load_data
);
   logic [31:0] mem_q;
   assign plane_rdata = mem_q;
   always_ff @(posedge clock) begin
      if (load) begin
         mem_q <= load_data;
      end else if (plane_we) begin
         mem_q <= plane_wdata;
      end
   end
endmodule

/* File: test/planar_graphics_datapath_tb.sv */
// Self-checking bench for the plane data path.
`timescale 1ns/100ps
`include "pgd_params.svh"
module planar_graphics_datapath_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic mem_wr = 1'b0;
   logic mem_rd = 1'b0;
   logic [7:0] mem_wdata = 8'h00;
   logic [7:0] mem_rdata;
   logic [7:0] seq_mode = 8'h00;
   logic [31:0] plane_rdata;
   logic [31:0] plane_wdata;
   logic plane_we;
   logic load = 1'b0;
   logic [31:0] load_data = 32'h0;
   logic [31:0] pl;
   logic [7:0] wmask [7] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h0B, 8'h00};
   int failures = 0;
   int cmp_count = 0;
   always #50 clock = ~clock;
   pgd_datapath uut (.clock(clock), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .sequencer_memory_mode(seq_mode), .plane_rdata(plane_rdata),
      .plane_wdata(plane_wdata), .plane_we(plane_we));
   pgd_plane_mem mem (.clock(clock), .plane_wdata(plane_wdata), .plane_we(plane_we),
      .plane_rdata(plane_rdata), .load(load), .load_data(load_data));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic io_cyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      io_wr = wr;
      io_rd = ~wr;
      io_addr = a;
      io_wdata = d;
      @(negedge clock);
      io_wr = 1'b0;
      io_rd = 1'b0;
   endtask
   task automatic reg_wr(input logic [3:0] i, input logic [7:0] d);
      io_cyc(1'b1, `PGD_PORT_INDEX, {4'h0, i});
      io_cyc(1'b1, `PGD_PORT_DATA, d);
   endtask
   task automatic reg_rd(input logic [3:0] i, input logic [7:0] e);
      io_cyc(1'b1, `PGD_PORT_INDEX, {4'h0, i});
      io_cyc(1'b0, `PGD_PORT_DATA, 8'h00);
      check({24'h0, io_rdata}, {24'h0, e});
   endtask
   task automatic rd(input logic [7:0] e);
      @(negedge clock);
      mem_rd = 1'b1;
      @(negedge clock);
      mem_rd = 1'b0;
      check({24'h0, mem_rdata}, {24'h0, e});
   endtask
   task automatic wr(input logic [7:0] d, input logic [31:0] e);
      @(negedge clock);
      mem_wr = 1'b1;
      mem_wdata = d;
      @(negedge clock);
      mem_wr = 1'b0;
      check({31'h0, plane_we}, 32'h1);
      check(plane_wdata, e);
   endtask
   task automatic prep(input logic [31:0] p);
      @(negedge clock);
      load = 1'b1;
      load_data = p;
      @(negedge clock);
      load = 1'b0;
      rd(p[7:0]);
   endtask
   function automatic logic [7:0] alu(input logic [7:0] d, input logic [7:0] l,
         input int r, input int f);
      logic [15:0] t;
      t = {d, d} >> r;
      case (f)
         1: return t[7:0] & l;
         2: return t[7:0] | l;
         3: return t[7:0] ^ l;
         default: return t[7:0];
      endcase
   endfunction
   function automatic logic [31:0] wexp(input logic [7:0] d, input logic [31:0] l,
         input int r, input int f, input logic [7:0] m);
      logic [31:0] e;
      for (int p = 0; p < 4; p++) begin
         e[8*p+:8] = (alu(d, l[8*p+:8], r, f) & m) | (l[8*p+:8] & ~m);
      end
      return e;
   endfunction
   function automatic logic [7:0] cmpx(input logic [31:0] p, input logic [3:0] c,
         input logic [3:0] k);
      logic [7:0] m;
      m = 8'hFF;
      for (int b = 0; b < 8; b++) begin
         for (int q = 0; q < 4; q++) begin
            if (k[q] && p[8*q+b] != c[q]) begin
               m[b] = 1'b0;
            end
         end
      end
      return m;
   endfunction
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 9; i++) begin
         reg_rd(i[3:0], i == 7 ? 8'h0F : i == 8 ? 8'hFF : 8'h00);
      end
      for (int i = 0; i < 7; i++) begin
         reg_wr(i[3:0], 8'hFF);
         reg_rd(i[3:0], wmask[i]);
      end
      io_cyc(1'b1, `PGD_PORT_INDEX, 8'hF2);
      io_cyc(1'b0, `PGD_PORT_INDEX, 8'h00);
      check({24'h0, io_rdata}, 32'h02);
      io_cyc(1'b0, `PGD_PORT_DATA, 8'h00);
      check({24'h0, io_rdata}, 32'h0F);
      io_cyc(1'b0, 16'h03CD, 8'h00);
      check({24'h0, io_rdata}, 32'h00);
      for (int i = 0; i < 6; i++) begin
         reg_wr(i[3:0], 8'h00);
      end
      pl = 32'h44332211;
      prep(pl);
      for (int m = 0; m < 4; m++) begin
         reg_wr(4'h4, m[7:0]);
         rd(pl[8*m+:8]);
      end
      seq_mode = 8'h08;
      rd(8'h11);
      seq_mode = 8'h00;
      reg_wr(4'h4, 8'h00);
      pl = 32'h00FEFFFF;
      prep(pl);
      reg_wr(4'h2, 8'h03);
      reg_wr(4'h5, 8'h08);
      reg_wr(4'h4, 8'h02);
      rd(cmpx(pl, 4'h3, 4'hF));
      reg_wr(4'h7, 8'h01);
      rd(cmpx(pl, 4'h3, 4'h1));
      reg_wr(4'h7, 8'h0B);
      rd(cmpx(pl, 4'h3, 4'hB));
      reg_wr(4'h7, 8'h00);
      rd(8'hFF);
      reg_wr(4'h5, 8'h00);
      rd(8'hFE);
      reg_wr(4'h4, 8'h00);
      pl = 32'h44332211;
      prep(pl);
      reg_wr(4'h0, 8'h04);
      reg_wr(4'h1, 8'h05);
      wr(8'hCD, 32'hCDFFCD00);
      reg_wr(4'h1, 8'h00);
      for (int f = 0; f < 4; f++) begin
         reg_wr(4'h3, {3'h0, f[1:0], 3'h3});
         wr(8'hCA, wexp(8'hCA, pl, 3, f, 8'hFF));
      end
      reg_wr(4'h3, 8'h00);
      reg_wr(4'h8, 8'h69);
      wr(8'h66, wexp(8'h66, pl, 0, 0, 8'h69));
      reg_wr(4'h5, 8'h01);
      wr(8'h5A, pl);
      final_report();
   end
endmodule
